/* core/watchdog_timer_unit.sv */
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module watchdog_timer_unit
  import watchdog_pkg::*;
#(
  parameter int PULSE_LEN = RESET_PULSE_LEN
) (
  input  wire logic              mclk_i,
  input  wire logic              reset_n_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              timebase_i,
  input  wire logic              hw_reset_n_i,
  input  wire logic              analog_supply_low_i,
  input  wire logic              digital_supply_low_i,
  output logic                   sys_reset_o,
  output logic                   dog_nmi_o,
  output logic                   irq_o,
  output logic                   supply_low_irq_o
);

  localparam int PC_W = $clog2(PULSE_LEN + 1);

  // pin synchronisers
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic              tb_prev_q;

  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++) begin : g_sync
      always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          sync1_q[g] <= SYNC_RESET[g];
          sync2_q[g] <= SYNC_RESET[g];
        end else begin
          sync1_q[g] <= (g == SYNC_TB)    ? timebase_i :
                        (g == SYNC_HWRST) ? hw_reset_n_i :
                        (g == SYNC_ALOW)  ? analog_supply_low_i :
                                            digital_supply_low_i;
          sync2_q[g] <= sync1_q[g];
        end
      end
    end
  endgenerate

  logic tick;
  logic hw_rst;
  logic supply_low;

  always_comb begin
    tick       = sync2_q[SYNC_TB] & ~tb_prev_q; // RULE1
    hw_rst     = ~sync2_q[SYNC_HWRST];
    supply_low = sync2_q[SYNC_ALOW] | sync2_q[SYNC_DLOW]; // RULE13
  end

  // apb slave, no wait states
  logic        pready_q;
  logic        pready_d;
  logic        pslverr_q;
  logic        pslverr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        setup;
  logic        done;
  logic        wr;
  logic        mapped;

  // register state
  dog_control_s          ctl_q;
  dog_control_s          ctl_d;
  unlock_e               lock_q;
  unlock_e               lock_d;
  logic [COUNT_W-1:0]    count_q;
  logic [COUNT_W-1:0]    count_d;
  logic [EV_W-1:0]       status_q;
  logic [EV_W-1:0]       status_d;
  logic [EV_W-1:0]       mask_q;
  logic [EV_W-1:0]       mask_d;
  logic [PC_W-1:0]       pulse_q;
  logic [PC_W-1:0]       pulse_d;
  logic                  sys_reset_q;
  logic                  sys_reset_d;
  logic                  nmi_q;
  logic                  nmi_d;
  logic                  irq_q;
  logic                  irq_d;
  logic                  slow_q;
  logic                  slow_d;

  // control write path
  logic                  ctl_access;
  logic [7:0]            eff;
  dog_control_s          eff_s;
  logic                  accept;
  logic                  arm;
  logic                  reject;
  logic                  kick;
  logic                  immediate;
  logic                  timed;
  logic                  timeout;
  logic [COUNT_W-1:0]    term;

  function automatic logic [COUNT_W-1:0] term_count(input logic [3:0] pre);
    logic [COUNT_W:0] one_hot;
    one_hot = {{COUNT_W{1'b0}}, 1'b1} << (TIMEOUT_BASE_LOG2 + int'(pre));
    return one_hot[COUNT_W-1:0] - {{(COUNT_W-1){1'b0}}, 1'b1}; // RULE2
  endfunction : term_count

  always_comb begin
    setup  = psel_i & ~penable_i;
    done   = psel_i & penable_i & pready_q;
    wr     = done & pwrite_i;
    mapped = (paddr_i == DOG_CONTROL_OFF) || (paddr_i == CONTROL_SET_OFF) ||
             (paddr_i == CONTROL_CLR_OFF) || (paddr_i == IRQ_STATUS_OFF) ||
             (paddr_i == IRQ_MASK_OFF)    || (paddr_i == DOG_COUNT_OFF);
    pready_d  = setup;
    pslverr_d = setup & ~mapped;
    prdata_d  = 32'h0000_0000;
    if (setup) begin
      case (paddr_i)
        DOG_CONTROL_OFF,
        CONTROL_SET_OFF,
        CONTROL_CLR_OFF: prdata_d = {24'h00_0000, ctl_q[7:1], lock_q == ARMED};
        IRQ_STATUS_OFF:  prdata_d = {{(32-EV_W){1'b0}}, status_q};
        IRQ_MASK_OFF:    prdata_d = {{(32-EV_W){1'b0}}, mask_q};
        DOG_COUNT_OFF:   prdata_d = {{(32-COUNT_W){1'b0}}, count_q};
        default:         prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  // control register, unlock sequence and counter
  always_comb begin
    ctl_access = wr && ((paddr_i == DOG_CONTROL_OFF) || (paddr_i == CONTROL_SET_OFF) ||
                        (paddr_i == CONTROL_CLR_OFF));
    case (paddr_i)
      CONTROL_SET_OFF: eff = {ctl_q[7:1], 1'b0} | pwdata_i[7:0]; // RULE11
      CONTROL_CLR_OFF: eff = {ctl_q[7:1], 1'b0} & ~pwdata_i[7:0]; // RULE11
      default:         eff = pwdata_i[7:0];
    endcase
    eff_s     = dog_control_s'(eff);
    accept    = ctl_access & (lock_q == ARMED) & ~hw_rst; // RULE10
    arm       = ctl_access & (lock_q == LOCKED) & eff_s.write_unlock;
    reject    = ctl_access & (lock_q == LOCKED) & ~eff_s.write_unlock;
    kick      = accept & eff_s.dog_enable_kick; // RULE7
    immediate = accept & (eff_s.timeout_prescale == PRE_IMMEDIATE); // RULE3
    timed     = ctl_q.dog_enable_kick & (ctl_q.timeout_prescale <= PRE_MAX_TIMED);
    term      = term_count(ctl_q.timeout_prescale);
    timeout   = tick & timed & (count_q == term) & ~kick; // RULE8

    lock_d = lock_q;
    case (lock_q)
      LOCKED:  if (arm) begin
        lock_d = ARMED;
      end
      ARMED:   if (done) begin
        lock_d = LOCKED; // RULE10
      end
      default: lock_d = LOCKED;
    endcase

    ctl_d = ctl_q;
    if (accept) begin
      ctl_d.timeout_prescale   = eff_s.timeout_prescale;
      ctl_d.timeout_irq_select = eff_s.timeout_irq_select;
      ctl_d.dog_enable_kick    = eff_s.dog_enable_kick; // RULE9
      ctl_d.timeout_flag       = ctl_q.timeout_flag & eff_s.timeout_flag; // RULE6
    end
    ctl_d.write_unlock = 1'b0;
    if (timeout & ~ctl_q.timeout_irq_select) begin
      ctl_d.dog_enable_kick = 1'b0; // RULE9
    end
    if (immediate | supply_low) begin
      ctl_d.dog_enable_kick = 1'b0; // RULE9
    end
    if (timeout | immediate) begin
      ctl_d.timeout_flag = 1'b1; // RULE6
    end
    if (hw_rst) begin
      ctl_d  = dog_control_s'(CONTROL_RESET); // RULE9
      lock_d = LOCKED;
    end

    count_d = count_q;
    if (kick | ~ctl_q.dog_enable_kick | hw_rst) begin
      count_d = '0; // RULE7
    end else if (tick & timed) begin
      count_d = timeout ? '0 : count_q + {{(COUNT_W-1){1'b0}}, 1'b1}; // RULE1
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctl_q     <= dog_control_s'(CONTROL_RESET); // RULE11
      lock_q    <= LOCKED;
      count_q   <= '0;
      tb_prev_q <= 1'b0;
    end else begin
      ctl_q     <= ctl_d;
      lock_q    <= lock_d;
      count_q   <= count_d;
      tb_prev_q <= sync2_q[SYNC_TB];
    end
  end

  // events, interrupts and reset pulse
  always_comb begin
    mask_d   = mask_q;
    status_d = status_q;
    if (wr && (paddr_i == IRQ_MASK_OFF)) begin
      mask_d = pwdata_i[EV_W-1:0];
    end
    if (wr && (paddr_i == IRQ_STATUS_OFF)) begin
      status_d = status_q & ~pwdata_i[EV_W-1:0];
    end
    if (timeout & ctl_q.timeout_irq_select) begin
      status_d[EV_IRQ_TIMEOUT] = 1'b1; // RULE4
    end
    if ((timeout & ~ctl_q.timeout_irq_select) | immediate) begin
      status_d[EV_RST_TIMEOUT] = 1'b1;
    end
    if (reject) begin
      status_d[EV_REJECT] = 1'b1;
    end
    nmi_d = status_d[EV_IRQ_TIMEOUT]; // RULE5
    irq_d = |(status_d & mask_d);
    slow_d = supply_low; // RULE13

    pulse_d = pulse_q;
    if ((timeout & ~ctl_q.timeout_irq_select) | immediate) begin
      pulse_d = PC_W'(PULSE_LEN); // RULE3
    end else if (pulse_q != '0) begin
      pulse_d = pulse_q - {{(PC_W-1){1'b0}}, 1'b1};
    end
    sys_reset_d = (pulse_d != '0); // RULE8
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_q    <= EV_RESET;
      mask_q      <= MASK_RESET;
      nmi_q       <= 1'b0;
      irq_q       <= 1'b0;
      slow_q      <= 1'b0;
      pulse_q     <= '0;
      sys_reset_q <= 1'b0;
    end else begin
      status_q    <= status_d;
      mask_q      <= mask_d;
      nmi_q       <= nmi_d;
      irq_q       <= irq_d;
      slow_q      <= slow_d;
      pulse_q     <= pulse_d;
      sys_reset_q <= sys_reset_d;
    end
  end

  assign prdata_o         = prdata_q;
  assign pready_o         = pready_q;
  assign pslverr_o        = pslverr_q;
  assign sys_reset_o      = sys_reset_q;
  assign dog_nmi_o        = nmi_q;
  assign irq_o            = irq_q;
  assign supply_low_irq_o = slow_q;

endmodule : watchdog_timer_unit

/* shared/watchdog_pkg.sv */
// Overview of operation
// RULE1: watchdog is a 16-bit counter advancing on each 32.768 kHz timebase tick
// RULE2: timeout is 2^prescale times 2^9 ticks; codes 0..7 give 15.6 ms to 2000 ms
// RULE3: prescale code 1000 forces an immediate system reset; codes above 1000 are reserved
// RULE4: with irq select set, a timeout raises an interrupt instead of a reset
// RULE5: watchdog interrupt is fixed high priority and ignores the global interrupt enable
// RULE6: timeout flag set on timeout; cleared by writing 0 or hardware reset only
// RULE7: writing 1 to enable enables the watchdog and clears its counter
// RULE8: software must rewrite enable before each timeout, else reset or interrupt follows
// RULE9: enable cleared by write 0, reset-mode timeout, hardware reset, supply-low interrupt
// RULE10: control write accepted only right after a write that set the unlock bit
// RULE11: control powers up at 10H and supports single-bit set and clear access
// RULE12: software should disable interrupts around the unlock then write pair
// RULE13: supply-low interrupt is high while either supply comparator reports low
package watchdog_pkg;

  localparam int          ADDR_W            = 12;
  localparam logic [11:0] DOG_CONTROL_OFF   = 12'h0c0;
  localparam logic [11:0] CONTROL_SET_OFF   = 12'h0c4;
  localparam logic [11:0] CONTROL_CLR_OFF   = 12'h0c8;
  localparam logic [11:0] IRQ_STATUS_OFF    = 12'h0cc;
  localparam logic [11:0] IRQ_MASK_OFF      = 12'h0d0;
  localparam logic [11:0] DOG_COUNT_OFF     = 12'h0d4;

  typedef struct packed {
    logic [3:0] timeout_prescale;
    logic       timeout_irq_select;
    logic       timeout_flag;
    logic       dog_enable_kick;
    logic       write_unlock;
  } dog_control_s;

  localparam logic [7:0]  CONTROL_RESET     = 8'h10;
  localparam logic [3:0]  PRE_MAX_TIMED     = 4'h7;
  localparam logic [3:0]  PRE_IMMEDIATE     = 4'h8;
  localparam int          TIMEOUT_BASE_LOG2 = 9;
  localparam int          COUNT_W           = 16;
  localparam int          TIMEBASE_HZ       = 32768;

  localparam int          EV_IRQ_TIMEOUT    = 0;
  localparam int          EV_RST_TIMEOUT    = 1;
  localparam int          EV_REJECT         = 2;
  localparam int          EV_W              = 3;
  localparam logic [2:0]  EV_RESET          = 3'h0;
  localparam logic [2:0]  MASK_RESET        = 3'h0;

  localparam int          RESET_PULSE_LEN   = 8;

  localparam int          SYNC_TB           = 0;
  localparam int          SYNC_HWRST        = 1;
  localparam int          SYNC_ALOW         = 2;
  localparam int          SYNC_DLOW         = 3;
  localparam int          SYNC_W            = 4;
  localparam logic [3:0]  SYNC_RESET        = 4'h2;

  typedef enum logic [1:0] {
    LOCKED = 2'b01,
    ARMED  = 2'b10
  } unlock_e;

endpackage : watchdog_pkg

/* sim/tb_top.sv */
`timescale 1ns/1ps
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, x); end end
module tb_top
  import watchdog_pkg::*;
;
  logic mclk_i = 0, reset_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, timebase_i = 0;
  logic hw_reset_n_i = 1, analog_supply_low_i = 0, digital_supply_low_i = 0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, rdv;
  logic pready_o, pslverr_o, sys_reset_o, dog_nmi_o, irq_o, supply_low_irq_o, err, rst_prev;
  int mismatches = 0, compares = 0, cycles = 0, rst_pulses = 0;

  watchdog_timer_unit dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .paddr_i(paddr_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .timebase_i(timebase_i),
    .hw_reset_n_i(hw_reset_n_i), .analog_supply_low_i(analog_supply_low_i),
    .digital_supply_low_i(digital_supply_low_i), .sys_reset_o(sys_reset_o),
    .dog_nmi_o(dog_nmi_o), .irq_o(irq_o), .supply_low_irq_o(supply_low_irq_o));

  always #4 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    rst_prev <= sys_reset_o;
    if (sys_reset_o === 1'b1 && rst_prev !== 1'b1) rst_pulses++;
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic summarize();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    rdv = prdata_o;
    err = pslverr_o;
    psel_i <= 0; penable_i <= 0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1, a, d);
    repeat (2) @(posedge mclk_i);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(0, a, 32'h0000_0000);
    `CHK(rdv, x)
  endtask : rd
  task automatic ctl(input logic [7:0] v);
    wr(DOG_CONTROL_OFF, 32'h0000_0001);
    wr(DOG_CONTROL_OFF, {24'h0, v});
  endtask : ctl
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk_i) timebase_i <= 1;
      @(posedge mclk_i);
      @(posedge mclk_i) timebase_i <= 0;
      @(posedge mclk_i);
    end
    repeat (6) @(posedge mclk_i);
  endtask : tick

  task automatic t_reset_lock();
    rd(DOG_CONTROL_OFF, 32'h0000_0010);
    rd(12'h0f0, 32'h0000_0000);
    `CHK(err, 1'b1)
    wr(DOG_CONTROL_OFF, 32'h0000_0012);
    rd(DOG_CONTROL_OFF, 32'h0000_0010);
    wr(DOG_CONTROL_OFF, 32'h0000_0001);
    rd(IRQ_STATUS_OFF, 32'h0000_0004);
    wr(DOG_CONTROL_OFF, 32'h0000_0012);
    rd(DOG_CONTROL_OFF, 32'h0000_0010);
    wr(IRQ_STATUS_OFF, 32'h0000_0004);
    rd(IRQ_STATUS_OFF, 32'h0000_0000);
    $display("test reset_lock done");
  endtask : t_reset_lock

  task automatic t_count();
    ctl(8'h02);
    tick(100);
    rd(DOG_COUNT_OFF, 32'h0000_0064);
    ctl(8'h02);
    rd(DOG_COUNT_OFF, 32'h0000_0000);
    $display("test count done");
  endtask : t_count

  task automatic t_irq();
    ctl(8'h0a);
    tick(511);
    `CHK(dog_nmi_o, 1'b0)
    tick(1);
    `CHK(dog_nmi_o, 1'b1)
    `CHK(rst_pulses, 0)
    rd(DOG_CONTROL_OFF, 32'h0000_000e);
    `CHK(irq_o, 1'b0)
    wr(IRQ_MASK_OFF, 32'h0000_0001);
    `CHK(irq_o, 1'b1)
    wr(IRQ_MASK_OFF, 32'h0000_0000);
    wr(IRQ_STATUS_OFF, 32'h0000_0001);
    `CHK({irq_o, dog_nmi_o}, 2'b00)
    ctl(8'h08);
    rd(DOG_CONTROL_OFF, 32'h0000_0008);
    $display("test irq done");
  endtask : t_irq

  task automatic t_rmode();
    ctl(8'h12);
    tick(1023);
    `CHK(rst_pulses, 0)
    tick(1);
    `CHK(rst_pulses, 1)
    rd(DOG_CONTROL_OFF, 32'h0000_0014);
    rd(IRQ_STATUS_OFF, 32'h0000_0002);
    ctl(8'h80);
    repeat (12) @(posedge mclk_i);
    `CHK(rst_pulses, 2)
    rd(DOG_CONTROL_OFF, 32'h0000_0084);
    $display("test rmode done");
  endtask : t_rmode

  task automatic t_hw_supply();
    hw_reset_n_i <= 0;
    repeat (6) @(posedge mclk_i);
    hw_reset_n_i <= 1;
    repeat (6) @(posedge mclk_i);
    rd(DOG_CONTROL_OFF, 32'h0000_0010);
    rd(IRQ_STATUS_OFF, 32'h0000_0002);
    wr(DOG_CONTROL_OFF, 32'h0000_0001);
    wr(CONTROL_SET_OFF, 32'h0000_000a);
    rd(DOG_CONTROL_OFF, 32'h0000_001a);
    wr(DOG_CONTROL_OFF, 32'h0000_0001);
    wr(CONTROL_CLR_OFF, 32'h0000_0018);
    rd(DOG_CONTROL_OFF, 32'h0000_0002);
    analog_supply_low_i <= 1;
    repeat (6) @(posedge mclk_i);
    `CHK(supply_low_irq_o, 1'b1)
    rd(DOG_CONTROL_OFF, 32'h0000_0000);
    analog_supply_low_i <= 0;
    digital_supply_low_i <= 1;
    repeat (6) @(posedge mclk_i);
    `CHK(supply_low_irq_o, 1'b1)
    digital_supply_low_i <= 0;
    repeat (6) @(posedge mclk_i);
    `CHK(supply_low_irq_o, 1'b0)
    $display("test hw_supply done");
  endtask : t_hw_supply

  task automatic t_kick();
    ctl(8'h02);
    tick(500);
    ctl(8'h02);
    tick(500);
    `CHK(rst_pulses, 2)
    rd(DOG_COUNT_OFF, 32'h0000_01f4);
    ctl(8'h92);
    tick(20);
    rd(DOG_COUNT_OFF, 32'h0000_0000);
    `CHK(rst_pulses, 2)
    $display("test kick done");
  endtask : t_kick

  initial begin
    repeat (5) @(posedge mclk_i);
    reset_n_i <= 1;
    t_reset_lock();
    t_count();
    t_irq();
    t_rmode();
    t_hw_supply();
    t_kick();
    summarize();
  end
endmodule : tb_top

/* sim/wdt_checker.sv */
`timescale 1ns/1ps
module wdt_checker
  import watchdog_pkg::*;
#(
  parameter int PULSE_LEN = RESET_PULSE_LEN
) (
  input wire logic              mclk_i,
  input wire logic              reset_n_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic [31:0]       prdata_o,
  input wire logic              pready_o,
  input wire logic              pslverr_o,
  input wire logic              analog_supply_low_i,
  input wire logic              digital_supply_low_i,
  input wire logic              sys_reset_o,
  input wire logic              dog_nmi_o,
  input wire logic              supply_low_irq_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  logic setup;
  logic mapped;
  logic low;
  assign setup  = psel_i && !penable_i;
  assign mapped = paddr_i inside {DOG_CONTROL_OFF, CONTROL_SET_OFF, CONTROL_CLR_OFF,
                                  IRQ_STATUS_OFF, IRQ_MASK_OFF, DOG_COUNT_OFF};
  assign low    = analog_supply_low_i || digital_supply_low_i;

  a_setup_gets_ready: assert property (setup |=> pready_o)
    else $error("no ready after setup");
  a_ready_has_cause: assert property (pready_o |-> $past(setup))
    else $error("ready without setup");
  a_unmapped_errs: assert property (setup && !mapped |=> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_no_err: assert property (setup && mapped |=> !pslverr_o)
    else $error("mapped access refused");
  a_reset_pulse_len: assert property ($rose(sys_reset_o) |-> sys_reset_o[*8] ##1 !sys_reset_o)
    else $error("reset pulse length wrong");
  a_supply_low_up: assert property (low[*6] |-> supply_low_irq_o)
    else $error("supply irq not raised");
  a_supply_low_down: assert property ((!low)[*6] |-> !supply_low_irq_o)
    else $error("supply irq not dropped");
  a_nmi_not_reset: assert property ($rose(dog_nmi_o) |-> !sys_reset_o)
    else $error("reset together with nmi");

  c_reset: cover property ($rose(sys_reset_o));
  c_nmi: cover property ($rose(dog_nmi_o));
  c_err: cover property (pready_o && pslverr_o);
  c_supply: cover property ($rose(supply_low_irq_o));
endmodule : wdt_checker

bind watchdog_timer_unit wdt_checker #(.PULSE_LEN(PULSE_LEN)) u_chk (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .paddr_i(paddr_i), .psel_i(psel_i),
  .penable_i(penable_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .analog_supply_low_i(analog_supply_low_i), .digital_supply_low_i(digital_supply_low_i),
  .sys_reset_o(sys_reset_o), .dog_nmi_o(dog_nmi_o), .supply_low_irq_o(supply_low_irq_o));
